// file: hdl/psc_pump_staging.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_consts.svh"

// What this block does
// - curve selector: 0 configured curve, 1 power 1.5, 2 square; default 0.
// - start-up frequency is the initial output frequency for auxiliary motors.
// - start-up frequency zero means no auxiliary motor is ever switched on.
// - start-up band setting, 0 to 600.00 Hz, defaults to 5.00 Hz.
// - wait the start delay, up to 6000.0 s, before switching a motor on.
// - wait the stop delay, up to 6000.0 s, before switching a motor off.
// - at most three motors; count equals terminals assigned to motor duty.
// - motors start 1,2,3 and stop in that order, first on first off.
// - command below sleep frequency for the sleep period shuts the output off.
// - output stays off until command frequency exceeds the revival frequency.
module psc_pump_staging #(
    parameter int unsigned TICK_CYCLES = `PSC_TICK_MS * `PSC_CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic runCmd,
    input wire logic [15:0] cmdFreq,
    input wire logic [15:0] outFreq,
    output logic [2:0] auxMotorOn,
    output logic outputOn,
    output logic sleepActive,
    output psc_pkg::psc_curve_t curveSel,
    output logic [15:0] auxInitFreq
);
    psc_pkg::psc_cfg_t cfg_reg;
    psc_pkg::psc_state_t state_reg;
    psc_pkg::psc_state_t state_next;
    logic [31:0] tickCnt_reg;
    logic tick;
    logic [1:0] onCount_reg;
    logic [1:0] startPtr_reg;
    logic [1:0] stopPtr_reg;
    logic [1:0] nAux;
    logic [15:0] lowFreq;
    logic canStage;
    logic startHold;
    logic stopHold;
    logic sleepHold;
    logic startDone;
    logic stopDone;
    logic sleepDone;
    logic addrHit;
    logic [31:0] rdVal;
    logic wrEn;

    // divider for the 0.1 s time base
    always_ff @(posedge sys_clk) begin
        if (rst || tickCnt_reg == 32'(TICK_CYCLES - 1)) begin
            tickCnt_reg <= 32'h0000_0000;
        end else begin
            tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
        end
    end
    assign tick = (tickCnt_reg == 32'(TICK_CYCLES - 1));

    // motors in use follow the terminals given motor duty
    assign nAux = 2'({1'b0, cfg_reg.auxMask[0]}) + 2'({1'b0, cfg_reg.auxMask[1]})
        + 2'({1'b0, cfg_reg.auxMask[2]});

    // stop threshold saturates at zero rather than wrapping
    assign lowFreq = (cfg_reg.startFreq > cfg_reg.startBand) ?
        cfg_reg.startFreq - cfg_reg.startBand : 16'h0000;
    assign canStage = (state_reg == psc_pkg::DRV_RUNNING) && (cfg_reg.startFreq != 16'h0000);
    assign startHold = canStage && (onCount_reg < nAux) && (outFreq >= cfg_reg.startFreq);
    assign stopHold = canStage && (onCount_reg != 2'h0) && (outFreq < lowFreq);
    assign sleepHold = (state_reg == psc_pkg::DRV_RUNNING) && (cmdFreq < cfg_reg.sleepFreq);

    // one timer per delay; each restarts when its condition lapses
    psc_delay_timer u_start_tmr (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .hold(startHold),
        .limit(cfg_reg.startDly),
        .done(startDone)
    );
    psc_delay_timer u_stop_tmr (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .hold(stopHold),
        .limit(cfg_reg.stopDly),
        .done(stopDone)
    );
    psc_delay_timer u_sleep_tmr (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .hold(sleepHold),
        .limit(cfg_reg.sleepPeriod),
        .done(sleepDone)
    );

    // run, sleep and wake sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            psc_pkg::DRV_STOPPED: begin
                if (runCmd) begin
                    state_next = psc_pkg::DRV_RUNNING;
                end
            end
            psc_pkg::DRV_RUNNING: begin
                if (!runCmd) begin
                    state_next = psc_pkg::DRV_STOPPED;
                end else if (sleepDone && sleepHold) begin
                    state_next = psc_pkg::DRV_SLEEPING;
                end
            end
            psc_pkg::DRV_SLEEPING: begin
                if (!runCmd) begin
                    state_next = psc_pkg::DRV_STOPPED;
                end else if (cmdFreq > cfg_reg.reviveFreq) begin
                    state_next = psc_pkg::DRV_RUNNING;
                end
            end
            default: state_next = psc_pkg::DRV_STOPPED;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= psc_pkg::DRV_STOPPED;
            outputOn <= 1'b0;
            sleepActive <= 1'b0;
        end else begin
            state_reg <= state_next;
            outputOn <= (state_next == psc_pkg::DRV_RUNNING);
            sleepActive <= (state_next == psc_pkg::DRV_SLEEPING);
        end
    end

    // staging queue: a ring of pointers keeps first-on first-off order
    always_ff @(posedge sys_clk) begin
        if (rst || !canStage) begin
            auxMotorOn <= 3'h0;
            onCount_reg <= 2'h0;
            startPtr_reg <= 2'h0;
            stopPtr_reg <= 2'h0;
        end else if (startDone && startHold) begin
            auxMotorOn[startPtr_reg] <= 1'b1;
            startPtr_reg <= (startPtr_reg + 2'h1 >= nAux) ? 2'h0 : startPtr_reg + 2'h1;
            onCount_reg <= onCount_reg + 2'h1;
        end else if (stopDone && stopHold) begin
            auxMotorOn[stopPtr_reg] <= 1'b0;
            stopPtr_reg <= (stopPtr_reg + 2'h1 >= nAux) ? 2'h0 : stopPtr_reg + 2'h1;
            onCount_reg <= onCount_reg - 2'h1;
        end
    end

    // setting mirrors toward the frequency generator and curve shaper
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            curveSel <= psc_pkg::CURVE_LINEAR;
            auxInitFreq <= 16'h0000;
        end else begin
            curveSel <= cfg_reg.curve;
            auxInitFreq <= cfg_reg.startFreq;
        end
    end

    // apb decode and readback
    always_comb begin
        addrHit = 1'b1;
        rdVal = 32'h0000_0000;
        case (paddr)
            `PSC_ADDR_CTRL: begin
                rdVal[`PSC_CTRL_CURVE] = cfg_reg.curve;
                rdVal[`PSC_CTRL_MASK] = cfg_reg.auxMask;
            end
            `PSC_ADDR_START_FREQ: rdVal[15:0] = cfg_reg.startFreq;
            `PSC_ADDR_START_BAND: rdVal[15:0] = cfg_reg.startBand;
            `PSC_ADDR_START_DLY: rdVal[15:0] = cfg_reg.startDly;
            `PSC_ADDR_STOP_DLY: rdVal[15:0] = cfg_reg.stopDly;
            `PSC_ADDR_SLEEP_FREQ: rdVal[15:0] = cfg_reg.sleepFreq;
            `PSC_ADDR_REVIVE_FREQ: rdVal[15:0] = cfg_reg.reviveFreq;
            `PSC_ADDR_SLEEP_PERIOD: rdVal[15:0] = cfg_reg.sleepPeriod;
            `PSC_ADDR_STATUS: begin
                rdVal[`PSC_STAT_AUX] = auxMotorOn;
                rdVal[`PSC_STAT_SLEEP] = sleepActive;
                rdVal[`PSC_STAT_COUNT] = onCount_reg;
            end
            default: addrHit = 1'b0;
        endcase
    end

    // one wait state so read data leave a flop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !addrHit;
            prdata <= rdVal;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
    assign wrEn = psel && penable && pready && pwrite && addrHit;

    // settings; oversize frequencies and delays clamp to the top of range, reserved curve 3 falls back to 0
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_reg <= '0;
            cfg_reg.curve <= psc_pkg::CURVE_LINEAR;
            cfg_reg.startBand <= `PSC_BAND_RST;
        end else if (wrEn) begin
            case (paddr)
                `PSC_ADDR_CTRL: begin
                    cfg_reg.curve <= (pwdata[`PSC_CTRL_CURVE] == `PSC_CURVE_RSVD) ?
                        psc_pkg::CURVE_LINEAR : psc_pkg::psc_curve_t'(pwdata[`PSC_CTRL_CURVE]);
                    cfg_reg.auxMask <= pwdata[`PSC_CTRL_MASK];
                end
                `PSC_ADDR_START_FREQ: cfg_reg.startFreq <= fclamp(pwdata, `PSC_FREQ_MAX);
                `PSC_ADDR_START_BAND: cfg_reg.startBand <= fclamp(pwdata, `PSC_FREQ_MAX);
                `PSC_ADDR_START_DLY: cfg_reg.startDly <= fclamp(pwdata, `PSC_DLY_MAX);
                `PSC_ADDR_STOP_DLY: cfg_reg.stopDly <= fclamp(pwdata, `PSC_DLY_MAX);
                `PSC_ADDR_SLEEP_FREQ: cfg_reg.sleepFreq <= fclamp(pwdata, `PSC_FREQ_MAX);
                `PSC_ADDR_REVIVE_FREQ: cfg_reg.reviveFreq <= fclamp(pwdata, `PSC_FREQ_MAX);
                `PSC_ADDR_SLEEP_PERIOD: cfg_reg.sleepPeriod <= fclamp(pwdata, `PSC_DLY_MAX);
                default: cfg_reg <= cfg_reg;
            endcase
        end
    end

    function automatic logic [15:0] fclamp(input logic [31:0] v, input logic [15:0] lim);
        fclamp = (v > {16'h0000, lim}) ? lim : v[15:0];
    endfunction

    // checking helper: ticks the start condition has been held
    logic [15:0] startHeld_reg;
    always_ff @(posedge sys_clk) begin
        if (rst || !startHold || startDone) begin
            startHeld_reg <= 16'h0000;
        end else if (tick && startHeld_reg != 16'hffff) begin
            startHeld_reg <= startHeld_reg + 16'h0001;
        end
    end

    // checking helper: ticks the stop condition has been held
    // a stop must never beat its delay, or a motor chatters on the band edge
    logic [15:0] stopHeld_reg;
    always_ff @(posedge sys_clk) begin
        if (rst || !stopHold || stopDone) begin
            stopHeld_reg <= 16'h0000;
        end else if (tick && stopHeld_reg != 16'hffff) begin
            stopHeld_reg <= stopHeld_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_zero_start_off: assert property ((cfg_reg.startFreq == 16'h0000) |=> auxMotorOn == 3'h0)
        else $error("motor on with zero start-up frequency");
    a_motor_count: assert property (onCount_reg == 2'($countones(auxMotorOn)) && onCount_reg <= nAux)
        else $error("motor count disagrees with outputs or duty terminals");
    a_start_order: assert property ((onCount_reg > $past(onCount_reg))
        |-> (auxMotorOn ^ $past(auxMotorOn)) == (3'h1 << $past(startPtr_reg)))
        else $error("motor started out of order");
    a_stop_order: assert property ((onCount_reg < $past(onCount_reg) && canStage)
        |-> (auxMotorOn ^ $past(auxMotorOn)) == (3'h1 << $past(stopPtr_reg)))
        else $error("motor stopped out of order");
    a_start_delay: assert property ((startDone && startHold) |-> startHeld_reg >= cfg_reg.startDly)
        else $error("motor started before start delay");
    a_start_level: assert property ((onCount_reg > $past(onCount_reg))
        |-> $past(outFreq >= cfg_reg.startFreq))
        else $error("motor started below start-up frequency");
    a_stop_level: assert property ((onCount_reg < $past(onCount_reg) && canStage)
        |-> $past(outFreq < lowFreq))
        else $error("motor stopped above lower band edge");
    a_sleep_entry: assert property ((state_reg == psc_pkg::DRV_RUNNING && runCmd
        && !sleepHold) |=> outputOn)
        else $error("output dropped without sleep condition");
    a_sleep_hold: assert property ((state_reg == psc_pkg::DRV_SLEEPING && runCmd
        && cmdFreq <= cfg_reg.reviveFreq) |=> !outputOn ##0 sleepActive)
        else $error("output woke below revival frequency");
    a_init_freq: assert property ($changed(cfg_reg.startFreq)
        |=> auxInitFreq == $past(cfg_reg.startFreq))
        else $error("initial frequency not following setting");
    a_stop_delay: assert property ((stopDone && stopHold)
        |-> stopHeld_reg >= cfg_reg.stopDly)
        else $error("motor stopped before stop delay");
    a_curve_follow: assert property (curveSel == $past(cfg_reg.curve))
        else $error("curve selector not following setting");
endmodule

`default_nettype wire

// file: common/psc_consts.svh
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

// register byte offsets
`define PSC_ADDR_CTRL 8'h00
`define PSC_ADDR_START_FREQ 8'h04
`define PSC_ADDR_START_BAND 8'h08
`define PSC_ADDR_START_DLY 8'h0c
`define PSC_ADDR_STOP_DLY 8'h10
`define PSC_ADDR_SLEEP_FREQ 8'h14
`define PSC_ADDR_REVIVE_FREQ 8'h18
`define PSC_ADDR_SLEEP_PERIOD 8'h1c
`define PSC_ADDR_STATUS 8'h20

// field positions
`define PSC_CTRL_CURVE 1:0
`define PSC_CTRL_MASK 4:2
`define PSC_STAT_AUX 2:0
`define PSC_STAT_SLEEP 3
`define PSC_STAT_COUNT 5:4

// frequencies in 0.01 Hz, delays in 0.1 s; both top out at 60000
`define PSC_FREQ_MAX 16'hea60
`define PSC_DLY_MAX 16'hea60
`define PSC_BAND_RST 16'h01f4
`define PSC_CURVE_RSVD 2'h3
`define PSC_NUM_AUX 3

// time base: one tick per 0.1 s at the system clock rate
`define PSC_TICK_MS 100
`define PSC_CLK_KHZ 40000

`endif

// file: common/psc_pkg.sv
package psc_pkg;

    typedef enum logic [1:0] {
        CURVE_LINEAR,
        CURVE_POW15,
        CURVE_SQUARE
    } psc_curve_t;

    typedef enum logic [1:0] {
        DRV_STOPPED,
        DRV_RUNNING,
        DRV_SLEEPING
    } psc_state_t;

    typedef struct packed {
        psc_curve_t curve;
        logic [2:0] auxMask;
        logic [15:0] startFreq;
        logic [15:0] startBand;
        logic [15:0] startDly;
        logic [15:0] stopDly;
        logic [15:0] sleepFreq;
        logic [15:0] reviveFreq;
        logic [15:0] sleepPeriod;
    } psc_cfg_t;

endpackage

// file: hdl/psc_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none

// counts ticks while hold stays high; pulses done once the limit is reached
module psc_delay_timer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic hold,
    input wire logic [15:0] limit,
    output logic done
);
    logic [15:0] cnt_reg;

    // a dropped hold restarts the wait, so a brief dip cannot slip through
    always_ff @(posedge sys_clk) begin
        if (rst || !hold) begin
            cnt_reg <= 16'h0000;
            done <= 1'b0;
        end else if (done) begin
            cnt_reg <= 16'h0000; // rearm for the next motor
            done <= 1'b0;
        end else if (cnt_reg >= limit) begin
            done <= 1'b1;
        end else if (tick) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// file: verif/psc_contactor_model.sv
`timescale 1ns/1ps
`default_nettype none

// auxiliary motor contactors: each coil pulls in one cycle after its terminal
module psc_contactor_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] auxMotorOn,
    output logic [2:0] closed
);
    // pickup lag so a glitching terminal shows up as a missed closure
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            closed <= 3'h0;
        end else begin
            closed <= auxMotorOn;
        end
    end
endmodule

`default_nettype wire

// file: verif/pump_staging_sleep_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module pump_staging_sleep_control_tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic runCmd = 1'b0;
    logic [15:0] cmdFreq = 16'h1770;
    logic [15:0] outFreq = 16'h0;
    logic [2:0] auxMotorOn;
    logic outputOn;
    logic sleepActive;
    psc_pkg::psc_curve_t curveSel;
    logic [15:0] auxInitFreq;
    logic [2:0] closed;
    int fails = 0;
    int nCompared = 0;
    logic [31:0] rv;
    logic re;

    // 40 MHz
    always #12.5 sys_clk = ~sys_clk;

    // four cycles per 0.1 s tick keeps delay runs short
    psc_pump_staging #(.TICK_CYCLES(4)) i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .runCmd(runCmd), .cmdFreq(cmdFreq),
        .outFreq(outFreq), .auxMotorOn(auxMotorOn), .outputOn(outputOn),
        .sleepActive(sleepActive), .curveSel(curveSel), .auxInitFreq(auxInitFreq));
    psc_contactor_model i_contactors (.sys_clk(sys_clk), .rst(rst), .auxMotorOn(auxMotorOn),
        .closed(closed));

    task automatic summarize();
        $display("compared %0d, mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // apb transfer; pready is sampled at the rising edge, data taken at that same edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        bit got;
        got = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (int i = 0; i < 20 && !got; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) begin
                got = 1;
                rv = prdata;
                re = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!got) begin
            check("apb answer", got, 1'b1);
            summarize();
        end
    endtask

    // sel 0: motor terminals, 1: sleep flag, 2: output enable
    task automatic waitFor(input int sel, input logic [2:0] exp, input int bound);
        logic [2:0] v;
        for (int i = 0; i <= bound; i++) begin
            @(negedge sys_clk);
            v = (sel == 0) ? auxMotorOn : (sel == 1) ? {2'h0, sleepActive} : {2'h0, outputOn};
            if (v === exp) return;
        end
        check("wait output", v, exp);
        summarize();
    endtask

    task automatic drive(input logic run, input logic [15:0] cmd, input logic [15:0] outf);
        @(posedge sys_clk);
        runCmd <= run;
        cmdFreq <= cmd;
        outFreq <= outf;
    endtask

    // ends mid-cycle so outputs are looked at once settled
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic t_defaults();
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl", rv, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        check("band", rv, 32'h1f4);
        apb(1'b0, 8'h20, 32'h0);
        check("status", rv, 32'h0);
    endtask

    task automatic t_regs();
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h00, k);
            apb(1'b0, 8'h00, 32'h0);
            check("curve", rv, (k == 3) ? 0 : k);
            check("curveSel", curveSel, (k == 3) ? 0 : k);
        end
        apb(1'b0, 8'h24, 32'h0);
        check("unmapped err", re, 1'b1);
        check("unmapped data", rv, 32'h0);
        apb(1'b1, 8'h24, 32'h5);
        check("unmapped write err", re, 1'b1);
        apb(1'b1, 8'h20, 32'h3f);
        apb(1'b0, 8'h20, 32'h0);
        check("status read only", rv, 32'h0);
        apb(1'b1, 8'h08, 32'h11170);
        apb(1'b0, 8'h08, 32'h0);
        check("band clamp", rv, 32'hea60);
        apb(1'b1, 8'h04, 32'h1388);
        idle(1);
        check("init freq", auxInitFreq, 16'h1388);
    endtask

    task automatic t_zero();
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h1c);
        drive(1'b1, 16'h1770, 16'h1770);
        idle(40);
        check("no motor at zero", auxMotorOn, 3'h0);
        drive(1'b0, 16'h1770, 16'h0);
    endtask

    task automatic t_stage();
        apb(1'b1, 8'h04, 32'h1388);
        apb(1'b1, 8'h08, 32'h7d0);
        apb(1'b1, 8'h0c, 32'h3);
        apb(1'b1, 8'h10, 32'h1);
        drive(1'b1, 16'h1770, 16'h1388);
        idle(8);
        check("start delay", auxMotorOn, 3'h0);
        waitFor(0, 3'h1, 30);
        waitFor(0, 3'h3, 30);
        waitFor(0, 3'h7, 30);
        apb(1'b0, 8'h20, 32'h0);
        check("count", rv[5:4], 2'h3);
        check("contactors", closed, 3'h7);
        drive(1'b1, 16'h1770, 16'hbb8);
        idle(30);
        check("band edge", auxMotorOn, 3'h7);
        drive(1'b1, 16'h1770, 16'hbb7);
        waitFor(0, 3'h6, 20);
        waitFor(0, 3'h4, 20);
        waitFor(0, 3'h0, 20);
        drive(1'b0, 16'h1770, 16'h0);
    endtask

    task automatic t_count();
        apb(1'b1, 8'h00, 32'h14);
        apb(1'b1, 8'h0c, 32'h0);
        drive(1'b1, 16'h1770, 16'h1388);
        idle(60);
        check("two motors", $countones(auxMotorOn), 2);
        apb(1'b0, 8'h20, 32'h0);
        check("count two", rv[5:4], 2'h2);
        drive(1'b0, 16'h1770, 16'h0);
    endtask

    task automatic t_sleep();
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h14, 32'h3e8);
        apb(1'b1, 8'h18, 32'hbb8);
        apb(1'b1, 8'h1c, 32'h2);
        drive(1'b1, 16'h1770, 16'h0);
        waitFor(2, 3'h1, 5);
        drive(1'b1, 16'h1f4, 16'h0);
        idle(4);
        check("not yet asleep", outputOn, 1'b1);
        waitFor(1, 3'h1, 40);
        check("output off", outputOn, 1'b0);
        drive(1'b1, 16'hbb8, 16'h0);
        idle(30);
        check("stay asleep", outputOn, 1'b0);
        drive(1'b1, 16'hbb9, 16'h0);
        waitFor(2, 3'h1, 20);
        check("awake", sleepActive, 1'b0);
    endtask

    // reset in mid-run: outputs drop, settings return to defaults, run resumes
    task automatic t_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        idle(2);
        check("reset output", outputOn, 1'b0);
        check("reset sleep", sleepActive, 1'b0);
        check("reset init freq", auxInitFreq, 16'h0);
        @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, 8'h08, 32'h0);
        check("band default", rv, 32'h1f4);
        apb(1'b0, 8'h18, 32'h0);
        check("revive default", rv, 32'h0);
        waitFor(2, 3'h1, 5);
    endtask

    // reset for four cycles, then the scenarios back to back
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_defaults();
        t_regs();
        t_zero();
        t_stage();
        t_count();
        t_sleep();
        t_reset();
        summarize();
    end
endmodule

`default_nettype wire
